// ### inc/dts_defs.svh
// Purpose: shared constants of the dual-target serial slave
// Assumes: included by bare name from the design files
// Notes:   the device codes, address limits and buffer sizes used by the logic are named here
//
// How it works
// - data rising while clock high is a stop; any operation aborts.
// - data falling while clock high is a start condition.
// - a start at any point aborts and waits for a new slave address.
// - supply below trip level aborts the transfer in progress.
// - data is stable and sampled while the clock line is high.
// - after eight bits the receiver pulls data low for one clock.
// - data left high in the acknowledge slot ends the operation.
// - upper address nibble 1010b selects memory, 1101b selects companion registers.
// - companion transactions never touch memory or its address latch.
// - address bits 2 and 1 must match the two select pins.
// - address bit 0 set means read, clear means write.
// - memory write carries two address bytes forming a 15-bit latch value.
// - reads start at the current latch value, kept until rewritten.
// - latch increments per data byte before acknowledge, wrapping 7FFFh to 0000h.
// - no limit on bytes per transaction.
// - companion target takes one address byte, 00h to 18h valid.
// - companion address above 18h gets no acknowledge and is abandoned.
// - read sends eight bits, acknowledge continues, no acknowledge ends.
// - bytes travel most significant bit first; writes are acknowledged unless the companion buffer is full.
// - a new operation is accepted right after a write, no busy time.
// - memory byte stored on its eighth bit; earlier start or stop discards it.
// - random read is an address write, repeated start, then read.
// - memory and register address latches are separate.
`ifndef DTS_DEFS_SVH
`define DTS_DEFS_SVH

`define DTS_MEM_ID    4'hA
`define DTS_CMP_ID    4'hD
`define DTS_REG_MAX   8'h18
`define DTS_REG_LAST  5'h18
`define DTS_MEM_LAST  15'h7FFF
`define DTS_LAST_BIT  3'h7
`define DTS_FIFO_W    13
`define DTS_FIFO_D    16
`define DTS_SYNC_W    5

`endif

// ### inc/dts_pkg.sv
// Purpose: types of the dual-target serial slave
// Assumes: nothing
// Notes:   state and byte-kind encodings
package dts_pkg;

  typedef enum logic [2:0]
  {
    S_IDLE = 3'h0,
    S_RX   = 3'h1,
    S_ACK  = 3'h2,
    S_TX   = 3'h3,
    S_MACK = 3'h4,
    S_IGN  = 3'h5,
    S_LOAD = 3'h6
  } dts_state_t;

  typedef enum logic [2:0]
  {
    K_DEV  = 3'h0,
    K_MHI  = 3'h1,
    K_MLO  = 3'h2,
    K_RADR = 3'h3,
    K_WDAT = 3'h4
  } dts_kind_t;

endpackage : dts_pkg

// ### hw/dts_top.sv
// Purpose: two-wire serial slave answering a byte memory and a companion register space
// Assumes: ref_clk far faster than the bus clock; bus pins are asynchronous
// Notes:   companion register writes leave through a FIFO; reads use regAddr/regRdData
`include "dts_defs.svh"

// ****************************************
// buffer between the bus and the register side
// ****************************************
module dts_fifo #(
  parameter int W = 8,
  parameter int D = 16
)(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         clkEn,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(D);

  logic [W-1:0]  store [D];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0]   cnt;
  logic          push;
  logic          pop;

  // the output register holds a word too, so it counts toward the depth
  assign inReady = ((cnt + {{AW{1'b0}}, outValid}) < DEPTH_C);
  assign push    = inValid && inReady;
  // output stage is a register so outValid and outData come from flip-flops
  assign pop     = (cnt != '0) && (!outValid || outReady);

  always_ff @(posedge clk)
  begin
    if (clkEn && push)
    begin
      store[wp] <= inData;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp       <= '0;
      rp       <= '0;
      cnt      <= '0;
      outValid <= 1'h0;
      outData  <= '0;
    end
    else if (clkEn)
    begin
      if (push)
      begin
        wp <= wp + 1'h1;
      end
      if (pop)
      begin
        rp      <= rp + 1'h1;
        outData <= store[rp];
      end
      if (push && !pop)
      begin
        cnt <= cnt + 1'h1;
      end
      else if (pop && !push)
      begin
        cnt <= cnt - 1'h1;
      end
      if (pop)
      begin
        outValid <= 1'h1;
      end
      else if (outReady)
      begin
        outValid <= 1'h0;
      end
    end
  end

endmodule : dts_fifo

// ****************************************
// serial slave
// ****************************************
module dts_top (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       clkEn,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  input  wire logic [1:0] devSelPin,
  input  wire logic       supplyLow,
  output logic [4:0]      regAddr,
  input  wire logic [7:0] regRdData,
  output logic            cmpWrValid,
  output logic [4:0]      cmpWrAddr,
  output logic [7:0]      cmpWrData,
  input  wire logic       cmpWrReady
);

  function automatic logic [14:0] dtsIncMem(input logic [14:0] a);
    return (a == `DTS_MEM_LAST) ? 15'h0000 : a + 15'h0001;
  endfunction : dtsIncMem

  function automatic logic [4:0] dtsIncReg(input logic [4:0] a);
    return (a == `DTS_REG_LAST) ? 5'h00 : a + 5'h01;
  endfunction : dtsIncReg

  // ****************************************
  // pin synchronisers and edge finding
  // ****************************************
  logic [`DTS_SYNC_W-1:0] s1;
  logic [`DTS_SYNC_W-1:0] s2;
  logic [`DTS_SYNC_W-1:0] s3;
  logic [`DTS_SYNC_W-1:0] stab;
  logic                   sclP;
  logic                   sdaP;
  logic                   sclF;
  logic                   sdaF;
  logic [1:0]             selF;
  logic                   lowF;
  logic                   sclRise;
  logic                   sclFall;
  logic                   start;
  logic                   stop;
  logic                   abort;

  // a level counts only once the second and third stages agree
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1   <= 5'h1F;
      s2   <= 5'h1F;
      s3   <= 5'h1F;
      stab <= 5'h1F;
      sclP <= 1'h1;
      sdaP <= 1'h1;
    end
    else if (clkEn)
    begin
      s1   <= {sclIn, sdaIn, devSelPin, supplyLow};
      s2   <= s1;
      s3   <= s2;
      stab <= (s2 & s3) | (stab & (s2 | s3));
      sclP <= stab[4];
      sdaP <= stab[3];
    end
  end

  assign sclF    = stab[4];
  assign sdaF    = stab[3];
  assign selF    = stab[2:1];
  assign lowF    = stab[0];
  assign sclRise = sclF && !sclP;
  assign sclFall = !sclF && sclP;
  assign start   = sclF && sclP && sdaP && !sdaF;
  assign stop    = sclF && sclP && !sdaP && sdaF;
  assign abort   = start || stop || lowF;

  // ****************************************
  // byte decode
  // ****************************************
  dts_pkg::dts_state_t state;
  dts_pkg::dts_kind_t  kind;
  logic [2:0]          bitCnt;
  logic [7:0]          sr;
  logic [7:0]          next_sr;
  logic                target;
  logic                reading;
  logic                byteDone;
  logic                devHit;
  logic                ackByte;
  logic                memWr;
  logic                fifoPush;
  logic                fifoInReady;
  logic                rdStep;
  logic [7:0]          memQ;
  logic [7:0]          txByte;
  logic [14:0]         memAddr;
  logic [6:0]          addrHi;
  logic [7:0]          mem [32768];

  always_comb
  begin
    next_sr  = {sr[6:0], sdaF};
    byteDone = (state == dts_pkg::S_RX) && sclRise && (bitCnt == `DTS_LAST_BIT);
    devHit   = ((next_sr[7:4] == `DTS_MEM_ID) || (next_sr[7:4] == `DTS_CMP_ID))
               && (next_sr[2:1] == selF);
    case (kind)
      dts_pkg::K_DEV:  ackByte = devHit;
      dts_pkg::K_MHI:  ackByte = 1'h1;
      dts_pkg::K_MLO:  ackByte = 1'h1;
      dts_pkg::K_RADR: ackByte = (next_sr <= `DTS_REG_MAX);
      dts_pkg::K_WDAT: ackByte = target || fifoInReady;
      default:         ackByte = 1'h0;
    endcase
    memWr    = byteDone && (kind == dts_pkg::K_WDAT) && target;
    fifoPush = byteDone && (kind == dts_pkg::K_WDAT) && !target && fifoInReady && !abort;
    rdStep   = (state == dts_pkg::S_TX) && sclFall && (bitCnt == `DTS_LAST_BIT) && !abort;
    txByte   = target ? memQ : regRdData;
  end

  // ****************************************
  // protocol state machine
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state   <= dts_pkg::S_IDLE;
      kind    <= dts_pkg::K_DEV;
      bitCnt  <= 3'h0;
      sr      <= 8'h00;
      target  <= 1'h0;
      reading <= 1'h0;
      sdaOe   <= 1'h0;
    end
    else if (clkEn)
    begin
      if (abort)
      begin
        state  <= (start && !lowF) ? dts_pkg::S_RX : dts_pkg::S_IDLE;
        kind   <= dts_pkg::K_DEV;
        bitCnt <= 3'h0;
        sdaOe  <= 1'h0;
      end
      else
      begin
        case (state)
          dts_pkg::S_RX:
          begin
            if (sclRise)
            begin
              sr     <= next_sr;
              bitCnt <= bitCnt + 3'h1;
              if (bitCnt == `DTS_LAST_BIT)
              begin
                // a refused byte leaves the slot undriven
                state <= ackByte ? dts_pkg::S_ACK : dts_pkg::S_IGN;
                case (kind)
                  dts_pkg::K_DEV:
                  begin
                    target  <= (next_sr[7:4] == `DTS_MEM_ID);
                    reading <= next_sr[0];
                    kind    <= (next_sr[7:4] == `DTS_MEM_ID) ? dts_pkg::K_MHI : dts_pkg::K_RADR;
                  end
                  dts_pkg::K_MHI:  kind <= dts_pkg::K_MLO;
                  dts_pkg::K_MLO:  kind <= dts_pkg::K_WDAT;
                  dts_pkg::K_RADR: kind <= dts_pkg::K_WDAT;
                  default:         kind <= dts_pkg::K_WDAT;
                endcase
              end
            end
          end
          dts_pkg::S_ACK:
          begin
            if (sclFall && !sdaOe)
            begin
              sdaOe <= 1'h1;
            end
            else if (sclFall)
            begin
              bitCnt <= 3'h0;
              if (reading)
              begin
                // first read bit goes out on the fall that ends the slot
                sr    <= txByte;
                sdaOe <= ~txByte[7];
                state <= dts_pkg::S_TX;
              end
              else
              begin
                sdaOe <= 1'h0;
                state <= dts_pkg::S_RX;
              end
            end
          end
          dts_pkg::S_TX:
          begin
            if (sclFall)
            begin
              if (bitCnt == `DTS_LAST_BIT)
              begin
                sdaOe <= 1'h0;
                state <= dts_pkg::S_MACK;
              end
              else
              begin
                sdaOe  <= ~sr[6];
                sr     <= {sr[6:0], 1'h0};
                bitCnt <= bitCnt + 3'h1;
              end
            end
          end
          dts_pkg::S_MACK:
          begin
            if (sclRise)
            begin
              state <= sdaF ? dts_pkg::S_IGN : dts_pkg::S_LOAD;
            end
          end
          dts_pkg::S_LOAD:
          begin
            if (sclFall)
            begin
              sr     <= txByte;
              sdaOe  <= ~txByte[7];
              bitCnt <= 3'h0;
              state  <= dts_pkg::S_TX;
            end
          end
          default:
          begin
            sdaOe <= 1'h0;
          end
        endcase
      end
    end
  end

  // open drain: only ever pulls low
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sdaOut <= 1'h0;
    end
    else if (clkEn)
    begin
      sdaOut <= 1'h0;
    end
  end

  // ****************************************
  // memory and its address latch
  // ****************************************
  // latch is only reset by rst_n, standing in for loss of supply
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      memAddr <= 15'h0000;
      addrHi  <= 7'h00;
    end
    else if (clkEn && !abort && target)
    begin
      if (byteDone && (kind == dts_pkg::K_MHI))
      begin
        addrHi <= next_sr[6:0];
      end
      else if (byteDone && (kind == dts_pkg::K_MLO))
      begin
        memAddr <= {addrHi, next_sr};
      end
      else if (memWr || rdStep)
      begin
        memAddr <= dtsIncMem(memAddr);
      end
    end
  end

  // write completes within the same cycle, so there is never a busy period
  always_ff @(posedge ref_clk)
  begin
    if (clkEn)
    begin
      if (memWr && !abort)
      begin
        mem[memAddr] <= next_sr;
      end
      memQ <= mem[memAddr];
    end
  end

  // ****************************************
  // companion register address and write path
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      regAddr <= 5'h00;
    end
    else if (clkEn && !abort && !target)
    begin
      if (byteDone && (kind == dts_pkg::K_RADR) && ackByte)
      begin
        regAddr <= next_sr[4:0];
      end
      else if (fifoPush || rdStep)
      begin
        regAddr <= dtsIncReg(regAddr);
      end
    end
  end

  // a full buffer refuses the byte with no acknowledge rather than lose it
  dts_fifo #(
    .W (`DTS_FIFO_W),
    .D (`DTS_FIFO_D)
  ) u_fifo (
    .clk      (ref_clk),
    .rst_n    (rst_n),
    .clkEn    (clkEn),
    .inValid  (fifoPush),
    .inReady  (fifoInReady),
    .inData   ({regAddr, next_sr}),
    .outValid (cmpWrValid),
    .outReady (cmpWrReady),
    .outData  ({cmpWrAddr, cmpWrData})
  );

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence ackStart;
    clkEn && !abort && (state == dts_pkg::S_ACK) && sclFall && !sdaOe;
  endsequence
  sequence readerQuits;
    clkEn && !abort && (state == dts_pkg::S_MACK) && sclRise && sdaF;
  endsequence

  stop_aborts_a: assert property (clkEn && stop |=> (state == dts_pkg::S_IDLE) && !sdaOe)
    else $error("stop did not abort");
  start_rearms_a: assert property (clkEn && start && !lowF |=> (state == dts_pkg::S_RX)
    && (kind == dts_pkg::K_DEV) && (bitCnt == 3'h0))
    else $error("start did not rearm address reception");
  low_supply_a: assert property (clkEn && lowF |=> (state == dts_pkg::S_IDLE) && !sdaOe)
    else $error("low supply did not abort");
  ack_drive_a: assert property (ackStart |=> sdaOe)
    else $error("acknowledge not driven");
  nack_ends_a: assert property (readerQuits |=> (state == dts_pkg::S_IGN) ##1 !sdaOe)
    else $error("no acknowledge did not end read");
  addr_mismatch_a: assert property (clkEn && !abort && byteDone && (kind == dts_pkg::K_DEV) && !devHit
    |=> (state == dts_pkg::S_IGN) && !sdaOe)
    else $error("mismatched address answered");
  reg_range_a: assert property (clkEn && !abort && byteDone && (kind == dts_pkg::K_RADR)
    && (next_sr > `DTS_REG_MAX) |=> (state == dts_pkg::S_IGN) ##1 !sdaOe)
    else $error("illegal register address acknowledged");
  mem_wrap_a: assert property (clkEn && !abort && memWr && (memAddr == `DTS_MEM_LAST)
    |=> memAddr == 15'h0000)
    else $error("address latch did not wrap");
  cmp_keeps_mem_a: assert property ((state != dts_pkg::S_IDLE) && (kind != dts_pkg::K_DEV) && !target
    |=> $stable(memAddr))
    else $error("companion access moved memory address");

endmodule : dts_top

// ### dv/dts_master.sv
// Purpose: behavioural two-wire bus master that drives the serial slave from the far side
// Assumes: bus bit of 200 ns, eight ref_clk cycles; clock idles high between frames
// Notes:   open drain: sdaPull high pulls the line low, released line floats to the pull-up

// ****************************************
// bus master model
// ****************************************
module dts_master (
  input  wire logic ref_clk,
  input  wire logic sdaLine,
  output logic      sclOut,
  output logic      sdaPull
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    sclOut  = 1'b1;
    sdaPull = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : wait_clk

  // data moves one cycle after the clock falls, never while it is high; the low phase
  // outlasts the slave's answer delay so its data has passed the filter before the clock rises
  task automatic put_bit(input logic b, output logic seen);
    wait_clk(1);
    sclOut = 1'b0;
    wait_clk(1);
    sdaPull = ~b;
    wait_clk(5);
    sclOut = 1'b1;
    wait_clk(1);
    seen = sdaLine;
  endtask : put_bit

  // also serves as repeated start: line released low-clock first
  task automatic start_cond();
    logic s;
    put_bit(1'b1, s);
    sdaPull = 1'b1;
    wait_clk(4);
  endtask : start_cond

  task automatic stop_cond();
    logic s;
    put_bit(1'b0, s);
    sdaPull = 1'b0;
    wait_clk(4);
  endtask : stop_cond

  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(b[i], s);
    put_bit(1'b1, s);
    ack = ~s;
  endtask : wr_byte

  task automatic part_byte(input logic [7:0] b, input int n);
    logic s;
    for (int i = 0; i < n; i++) put_bit(b[7-i], s);
  endtask : part_byte

  // the last wanted byte is never acknowledged, so the slave lets go of the line
  task automatic rd_byte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(1'b1, d[i]);
    put_bit(~more, s);
  endtask : rd_byte
endmodule : dts_master

// ### dv/dts_top_tb_top.sv
// Purpose: self-checking bench of the dual-target serial slave
// Assumes: bus master model drives the link; bench models the companion register side
// Notes:   memory contents are checked by write then read back over the bus
`include "dts_defs.svh"

module dts_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic       ref_clk, rst_n, clkEn, sclOut, sdaPull, sdaLine, sdaOut, sdaOe, supplyLow;
  logic [1:0] devSelPin;
  logic [4:0] regAddr, cmpWrAddr;
  logic [7:0] regRdData, cmpWrData, d;
  logic       cmpWrValid, cmpWrReady, ack, oeSeen;
  logic [7:0] regFile [0:31];
  logic [4:0] gotA [$];
  logic [7:0] gotD [$];
  int         errors, checks_done;

  // the line is low while any party pulls it
  assign sdaLine   = ~(sdaPull | (sdaOe & ~sdaOut));
  assign regRdData = regFile[regAddr];

  dts_top dts_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn), .sclIn(sclOut), .sdaIn(sdaLine),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .devSelPin(devSelPin), .supplyLow(supplyLow), .regAddr(regAddr),
    .regRdData(regRdData), .cmpWrValid(cmpWrValid), .cmpWrAddr(cmpWrAddr), .cmpWrData(cmpWrData),
    .cmpWrReady(cmpWrReady));

  dts_master dts_master_i (.ref_clk(ref_clk), .sdaLine(sdaLine), .sclOut(sclOut), .sdaPull(sdaPull));

  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
  begin
    if (sdaOe === 1'b1) oeSeen <= 1'b1;
    if (cmpWrValid === 1'b1 && cmpWrReady)
    begin
      gotA.push_back(cmpWrAddr);
      gotD.push_back(cmpWrData);
      regFile[cmpWrAddr] <= cmpWrData;
    end
  end

  // ****************************************
  // shared helpers
  // ****************************************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic [7:0] dev(input logic [3:0] id, input logic rd);
    return {id, 1'b0, devSelPin, rd};
  endfunction : dev

  task automatic send(input logic [7:0] b, input logic expAck);
    dts_master_i.wr_byte(b, ack);
    check("acknowledge", ack, expAck);
  endtask : send

  task automatic fetch(input logic more, input logic [7:0] exp);
    dts_master_i.rd_byte(more, d);
    check("read byte", d, exp);
  endtask : fetch

  task automatic mem_addr(input logic [7:0] hi, input logic [7:0] lo);
    dts_master_i.start_cond();
    send(dev(`DTS_MEM_ID, 1'b0), 1'b1);
    send(hi, 1'b1);
    send(lo, 1'b1);
  endtask : mem_addr

  task automatic mem_rd_start();
    dts_master_i.start_cond();
    send(dev(`DTS_MEM_ID, 1'b1), 1'b1);
  endtask : mem_rd_start

  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_mem();
    mem_addr(8'h7F, 8'hFE);
    send(8'hA5, 1'b1);
    send(8'h3C, 1'b1);
    send(8'h96, 1'b1);
    send(8'hE1, 1'b1);
    dts_master_i.stop_cond();
    mem_addr(8'hFF, 8'hFE);
    mem_rd_start();
    fetch(1'b1, 8'hA5);
    fetch(1'b0, 8'h3C);
    dts_master_i.stop_cond();
    mem_rd_start();
    fetch(1'b0, 8'h96);
    dts_master_i.stop_cond();
    $display("test_mem done");
  endtask : test_mem

  task automatic test_select();
    devSelPin = 2'b01;
    for (int s = 0; s < 4; s++)
    begin
      oeSeen = 1'b0;
      dts_master_i.start_cond();
      send({`DTS_MEM_ID, 1'b0, s[1:0], 1'b0}, s == 1);
      send(8'h00, s == 1);
      dts_master_i.stop_cond();
      check("drive while unselected", oeSeen, s == 1);
    end
    dts_master_i.start_cond();
    send({4'hB, 1'b0, devSelPin, 1'b0}, 1'b0);
    dts_master_i.stop_cond();
    devSelPin = 2'b10;
    $display("test_select done");
  endtask : test_select

  task automatic test_cmp();
    dts_master_i.start_cond();
    send(dev(`DTS_CMP_ID, 1'b0), 1'b1);
    send(8'h17, 1'b1);
    send(8'h11, 1'b1);
    send(8'h22, 1'b1);
    send(8'h33, 1'b1);
    dts_master_i.stop_cond();
    check("word count", gotA.size(), 3);
    check("word address", gotA.pop_front(), 8'h17);
    check("word address", gotA.pop_front(), 8'h18);
    check("word address", gotA.pop_front(), 8'h00);
    check("word data", gotD.pop_front(), 8'h11);
    check("word data", gotD.pop_front(), 8'h22);
    check("word data", gotD.pop_front(), 8'h33);
    dts_master_i.start_cond();
    send(dev(`DTS_CMP_ID, 1'b0), 1'b1);
    send(`DTS_REG_MAX + 8'h01, 1'b0);
    send(8'h44, 1'b0);
    dts_master_i.stop_cond();
    check("word count", gotA.size(), 0);
    dts_master_i.start_cond();
    send(dev(`DTS_CMP_ID, 1'b0), 1'b1);
    send(8'h17, 1'b1);
    dts_master_i.start_cond();
    send(dev(`DTS_CMP_ID, 1'b1), 1'b1);
    fetch(1'b1, 8'h11);
    fetch(1'b0, 8'h22);
    dts_master_i.stop_cond();
    mem_rd_start();
    fetch(1'b0, 8'hE1);
    dts_master_i.stop_cond();
    $display("test_cmp done");
  endtask : test_cmp

  task automatic test_abort();
    mem_addr(8'h00, 8'h10);
    send(8'h5A, 1'b1);
    send(8'hC3, 1'b1);
    dts_master_i.stop_cond();
    mem_addr(8'h00, 8'h10);
    send(8'h11, 1'b1);
    dts_master_i.part_byte(8'h22, 4);
    mem_rd_start();
    fetch(1'b0, 8'hC3);
    dts_master_i.stop_cond();
    mem_addr(8'h00, 8'h11);
    dts_master_i.part_byte(8'h44, 5);
    dts_master_i.stop_cond();
    dts_master_i.start_cond();
    send(8'h00, 1'b0);
    dts_master_i.stop_cond();
    mem_addr(8'h00, 8'h11);
    dts_master_i.part_byte(8'h55, 3);
    supplyLow = 1'b1;
    repeat (20) @(negedge ref_clk);
    supplyLow = 1'b0;
    repeat (8) @(negedge ref_clk);
    send(8'h55, 1'b0);
    dts_master_i.stop_cond();
    mem_addr(8'h00, 8'h10);
    mem_rd_start();
    fetch(1'b1, 8'h11);
    fetch(1'b0, 8'hC3);
    dts_master_i.stop_cond();
    $display("test_abort done");
  endtask : test_abort

  // sink stalls while the bus fills the buffer, then drains it with gaps
  task automatic test_fifo();
    cmpWrReady = 1'b0;
    dts_master_i.start_cond();
    send(dev(`DTS_CMP_ID, 1'b0), 1'b1);
    send(8'h00, 1'b1);
    for (int i = 0; i < `DTS_FIFO_D; i++) send(8'h80 + i[7:0], 1'b1);
    send(8'hF0, 1'b0);
    dts_master_i.stop_cond();
    repeat (40)
    begin
      @(negedge ref_clk);
      cmpWrReady = ~cmpWrReady;
    end
    cmpWrReady = 1'b1;
    repeat (4) @(negedge ref_clk);
    check("word count", gotA.size(), `DTS_FIFO_D);
    check("buffer empty", cmpWrValid, 1'b0);
    for (int i = 0; i < `DTS_FIFO_D; i++)
    begin
      check("word address", gotA.pop_front(), i[4:0]);
      check("word data", gotD.pop_front(), 8'h80 + i[7:0]);
    end
    $display("test_fifo done");
  endtask : test_fifo

  // ****************************************
  // run control
  // ****************************************
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report

  initial
  begin
    rst_n      = 1'b0;
    clkEn      = 1'b1;
    devSelPin  = 2'b10;
    supplyLow  = 1'b0;
    cmpWrReady = 1'b1;
    oeSeen     = 1'b0;
    errors     = 0;
    checks_done = 0;
    for (int i = 0; i < 32; i++) regFile[i] = i[7:0] ^ 8'h5A;
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (8) @(negedge ref_clk);
    test_mem();
    test_select();
    test_cmp();
    test_abort();
    test_fifo();
    final_report();
  end

  // about 85 bus bytes of 72 cycles each are expected; a hang gets several times that
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    errors++;
    $display("watchdog expired");
    final_report();
  end
endmodule : dts_top_tb_top
